// file: src/wwdt_core.sv
// processor core end: apb registers, clear and power-save commands
`timescale 1ns/1ps
module wwdt_core import wwdt_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fail_safe_switch,
    wwdt_link_if.core        lk,
    output logic             core_reset
);
    // all state of the core end
    typedef struct packed {
        logic                soft_en;  // soft enable bit
        logic                timeout_flag;     // time-out flag
        logic                slp;      // sleep status
        logic                idl;      // idle status
        logic                wrst;     // watchdog reset seen
        logic                asleep;   // core in power save
        logic                busy;     // clock switch running
        logic [SW_CNT_W-1:0] cnt;      // clock switch countdown
        logic                clr;      // clear pulse
        logic                pse;      // entry pulse
        logic                pse_idle; // entry is idle
        logic                psx;      // exit pulse
        logic                csd;      // switch done pulse
        logic                rst;      // core reset pulse
        logic                rdy;      // apb ready
        logic                err;      // apb error
        logic [31:0]         rdata;    // apb read data
    } wwdt_core_t;

    wwdt_core_t s;
    wwdt_core_t next_s;
    logic       wr;                    // write takes effect
    logic       hit;                   // mapped address
    logic [31:0] reset_control_reg_word;            // reset control view

    // next-state logic
    always_comb begin
        next_s          = s;
        next_s.clr      = 1'b0;
        next_s.pse      = 1'b0;
        next_s.psx      = 1'b0;
        next_s.csd      = 1'b0;
        next_s.rst      = 1'b0;
        hit             = (paddr == CTRL_OFF) || (paddr == RESET_CONTROL_REG_OFF);
        wr              = psel & penable & s.rdy & pwrite & hit;
        reset_control_reg_word       = RESET_CONTROL_REG_RESET;
        reset_control_reg_word[RESET_CONTROL_REG_SWEN_BIT]  = s.soft_en;
        reset_control_reg_word[RESET_CONTROL_REG_TIMEOUT_FLAG_BIT]  = s.timeout_flag;
        reset_control_reg_word[RESET_CONTROL_REG_SLEEP_BIT] = s.slp;
        reset_control_reg_word[RESET_CONTROL_REG_IDLE_BIT]  = s.idl;
        reset_control_reg_word[RESET_CONTROL_REG_WRST_BIT]  = s.wrst;

        // apb answer in the first access cycle
        next_s.rdy   = psel & ~penable;
        next_s.err   = psel & ~penable & ~hit;
        next_s.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (paddr == RESET_CONTROL_REG_OFF) begin
                next_s.rdata = reset_control_reg_word;
            end else if (paddr == CTRL_OFF) begin
                next_s.rdata[CTRL_ASLP_BIT] = s.asleep;
                next_s.rdata[CTRL_BUSY_BIT] = s.busy;
            end
        end

        // software writes reset control bits
        if (wr && paddr == RESET_CONTROL_REG_OFF) begin
            next_s.soft_en = pwdata[RESET_CONTROL_REG_SWEN_BIT];
            next_s.timeout_flag    = pwdata[RESET_CONTROL_REG_TIMEOUT_FLAG_BIT];
            next_s.slp     = pwdata[RESET_CONTROL_REG_SLEEP_BIT];
            next_s.idl     = pwdata[RESET_CONTROL_REG_IDLE_BIT];
            next_s.wrst    = pwdata[RESET_CONTROL_REG_WRST_BIT];
        end

        // command register
        if (wr && paddr == CTRL_OFF) begin
            if (pwdata[CTRL_CLR_BIT] && !s.asleep) begin
                next_s.clr = 1'b1;
            end
            if ((pwdata[CTRL_SLEEP_BIT] || pwdata[CTRL_IDLE_BIT]) && !s.asleep) begin
                next_s.pse      = 1'b1;
                next_s.pse_idle = pwdata[CTRL_IDLE_BIT];
                next_s.asleep   = 1'b1;
                next_s.idl      = pwdata[CTRL_IDLE_BIT];
                next_s.slp      = ~pwdata[CTRL_IDLE_BIT];
            end
            if (pwdata[CTRL_EXIT_BIT] && s.asleep) begin
                next_s.psx    = 1'b1;
                next_s.asleep = 1'b0;
            end
            if (pwdata[CTRL_OSW_BIT] && !s.busy) begin
                next_s.busy = 1'b1;
                next_s.cnt  = SW_CNT_W'(CLK_SWITCH_CYCLES - 1);
            end
        end

        // clock switch countdown, or fail-safe switch
        if (s.busy) begin
            if (s.cnt == '0) begin
                next_s.busy = 1'b0;
                next_s.csd  = 1'b1;
            end else begin
                next_s.cnt = s.cnt - 1'b1;
            end
        end
        if (fail_safe_switch) begin
            next_s.csd = 1'b1;
        end

        // watchdog wake resumes execution
        if (lk.wake) begin
            next_s.asleep = 1'b0;
        end

        // hardware set wins over software clear
        if (lk.timeout) begin
            next_s.timeout_flag = 1'b1;
        end

        // watchdog reset: core restarts
        if (lk.reset_req) begin
            next_s.soft_en = 1'b0;
            next_s.asleep  = 1'b0;
            next_s.busy    = 1'b0;
            next_s.wrst    = 1'b1;
            next_s.rst     = 1'b1;
        end
    end

    // state register, frozen while ce low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // outputs straight from flops
    assign prdata         = s.rdata;
    assign pready         = s.rdy;
    assign pslverr        = s.err;
    assign core_reset     = s.rst;
    assign lk.clear_pulse = s.clr;
    assign lk.ps_enter    = s.pse;
    assign lk.ps_idle     = s.pse_idle;
    assign lk.ps_exit     = s.psx;
    assign lk.switch_done = s.csd;
    assign lk.soft_enable = s.soft_en;
endmodule

// file: src/wwdt_pkg.sv
// windowed watchdog constants, field layouts and shared types
package wwdt_pkg;
    // clock and timing
    localparam int unsigned PCLK_PERIOD_NS    = 10;
    localparam int unsigned CLK_SWITCH_NS     = 200;
    localparam int unsigned CLK_SWITCH_CYCLES = (CLK_SWITCH_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
    localparam int unsigned SW_CNT_W          = 8;
    // config word field positions
    localparam int unsigned CFG_W          = 8;
    localparam int unsigned CFG_POST_LSB   = 0;
    localparam int unsigned CFG_POST_W     = 4;
    localparam int unsigned CFG_PRE_BIT    = 4;
    localparam int unsigned CFG_WINDOW_DISABLE_BIT = 6;
    localparam int unsigned CFG_FEN_BIT    = 7;
    // prescaler: 5 bit (div 32) or 7 bit (div 128)
    localparam int unsigned PRE_W          = 7;
    localparam logic [2:0]  PRE_BITS_SHORT = 3'h5;
    localparam logic [2:0]  PRE_BITS_LONG  = 3'h7;
    localparam logic [6:0]  PRE_LAST_SHORT = 7'h1F;
    localparam logic [6:0]  PRE_LAST_LONG  = 7'h7F;
    // postscaler: 16 ratios 1:1 .. 1:32768
    localparam int unsigned POST_W         = 15;
    localparam int unsigned PROG_W         = 23;
    localparam int unsigned CMP_W          = 26;
    // core register byte offsets
    localparam logic [11:0] CTRL_OFF       = 12'h000;
    localparam logic [11:0] RESET_CONTROL_REG_OFF       = 12'h004;
    // control register bits (write one to act; bits 8 and 9 are read-only status)
    localparam int unsigned CTRL_CLR_BIT   = 0;
    localparam int unsigned CTRL_SLEEP_BIT = 1;
    localparam int unsigned CTRL_IDLE_BIT  = 2;
    localparam int unsigned CTRL_EXIT_BIT  = 3;
    localparam int unsigned CTRL_OSW_BIT   = 4;
    localparam int unsigned CTRL_ASLP_BIT  = 8;
    localparam int unsigned CTRL_BUSY_BIT  = 9;
    // reset control register bits
    localparam int unsigned RESET_CONTROL_REG_WRST_BIT  = 1;
    localparam int unsigned RESET_CONTROL_REG_IDLE_BIT  = 2;
    localparam int unsigned RESET_CONTROL_REG_SLEEP_BIT = 3;
    localparam int unsigned RESET_CONTROL_REG_TIMEOUT_FLAG_BIT  = 4;
    localparam int unsigned RESET_CONTROL_REG_SWEN_BIT  = 5;
    localparam logic [31:0] RESET_CONTROL_REG_RESET     = 32'h0000_0000;
    // power mode of the device
    typedef enum logic [1:0] {
        WWDT_RUN   = 2'b00,
        WWDT_SLEEP = 2'b01,
        WWDT_IDLE  = 2'b10
    } wwdt_mode_t;
    // closed part of the period, in eighths, per window setting
    function automatic logic [3:0] wwdt_closed_eighths(input logic [1:0] sel);
        case (sel)
            2'h0:    wwdt_closed_eighths = 4'h6;
            2'h1:    wwdt_closed_eighths = 4'h5;
            2'h2:    wwdt_closed_eighths = 4'h4;
            default: wwdt_closed_eighths = 4'h2;
        endcase
    endfunction
endpackage

// file: src/wwdt_link_if.sv
// link between the watchdog and the processor core
`timescale 1ns/1ps
interface wwdt_link_if;
    logic clear_pulse;      // core: clear instruction executed
    logic ps_enter;         // core: power-save instruction executed
    logic ps_idle;          // core: with ps_enter, idle rather than sleep
    logic ps_exit;          // core: left power save by other cause
    logic switch_done;      // core: clock switch completed
    logic soft_enable;      // core: software enable level
    logic wake;             // watchdog: time-out wake from power save
    logic reset_req;        // watchdog: device reset request
    logic timeout;          // watchdog: time-out event
    modport dev  (input clear_pulse, ps_enter, ps_idle, ps_exit, switch_done, soft_enable,
                  output wake, reset_req, timeout);
    modport core (output clear_pulse, ps_enter, ps_idle, ps_exit, switch_done, soft_enable,
                  input wake, reset_req, timeout);
endinterface

// file: src/wwdt_sync.sv
// two flip-flop synchroniser for an outside level
`timescale 1ns/1ps
module wwdt_sync import wwdt_pkg::*; (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);
    // both stages in one record
    typedef struct packed {
        logic s1;   // first stage, read only by s2
        logic s2;   // second stage, safe to use
    } wwdt_sync_t;

    wwdt_sync_t s;
    wwdt_sync_t next_s;

    // shift the level through
    always_comb begin
        next_s    = s;
        next_s.s1 = din;
        next_s.s2 = s.s1;
    end

    // register, frozen while ce low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign dout = s.s2;
endmodule

// file: src/wwdt_device.sv
// windowed watchdog timer: counter, scalers, window check, wake and reset
// Operation
// - counter runs on rc clock, enable starts it
// - prescaler divides by 32 or 128
// - postscaler has 16 ratios, 1:1 to 1:32768
// - device reset clears counter and scalers
// - completed clock switch clears counter and scalers
// - power-save entry clears counter and scalers
// - leaving power save clears counter and scalers
// - clear instruction in run clears all counts
// - watchdog keeps counting in sleep and idle
// - time-out in power save wakes the core
// - software clears sleep/idle status after wake
// - fixed enable forces watchdog on always
// - otherwise soft enable bit controls the watchdog
// - soft enable cleared on every device reset
// - time-out sets sticky flag, software clears it
// - windowed mode: clear only inside chosen window
`timescale 1ns/1ps
module wwdt_device import wwdt_pkg::*; (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic             low_power_rc_clock,
    input  wire logic [CFG_W-1:0] watchdog_config_word,
    input  wire logic [1:0]       window_select,
    wwdt_link_if.dev              lk,
    output logic                  low_power_rc_clock_enable,
    output logic                  window_open
);
    // all state of the watchdog
    typedef struct packed {
        wwdt_mode_t        mode;       // run, sleep or idle
        logic              tick_d;     // last synced rc level
        logic [PRE_W-1:0]  pre;        // prescaler count
        logic [POST_W-1:0] post;       // postscaler count
        logic              low_power_rc_clock_en;    // rc oscillator enable
        logic              win;        // window open flag
        logic              wake;       // wake pulse
        logic              rst_req;    // reset request pulse
        logic              timeout;    // time-out pulse
    } wwdt_dev_t;

    wwdt_dev_t s;                      // current state
    wwdt_dev_t next_s;                 // next state

    logic                  tick_s;     // synced rc clock level
    logic                  en;         // watchdog enabled
    logic                  pre_long;   // divide by 128 chosen
    logic [CFG_POST_W-1:0] post_sel;   // postscale ratio index
    logic [PRE_W-1:0]      pre_last;   // prescaler wrap value
    logic [2:0]            pre_bits;   // prescaler width
    logic [POST_W-1:0]     post_last;  // postscaler wrap value
    logic                  tick_rise;  // one rc clock edge
    logic [PROG_W-1:0]     prog;       // progress in the period
    logic [PROG_W-1:0]     period;     // full period in rc edges
    logic                  win_ok;     // clear allowed now
    logic                  clr;        // clear counts this cycle

    // rc clock arrives from outside the pclk domain
    wwdt_sync u_rc_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     (low_power_rc_clock),
        .dout    (tick_s)
    );

    // configuration decode
    always_comb begin
        // fixed enable overrides the software bit
        en        = watchdog_config_word[CFG_FEN_BIT] | lk.soft_enable;
        // scaler widths and wrap points
        pre_long  = watchdog_config_word[CFG_PRE_BIT];
        post_sel  = watchdog_config_word[CFG_POST_LSB +: CFG_POST_W];
        pre_last  = pre_long ? PRE_LAST_LONG : PRE_LAST_SHORT;
        pre_bits  = pre_long ? PRE_BITS_LONG : PRE_BITS_SHORT;
        post_last = POST_W'((32'h1 << post_sel) - 32'h1);
        // one rising edge of the synced rc level
        tick_rise = tick_s & ~s.tick_d;
    end

    // window position: progress against closed eighths
    always_comb begin
        // rc edges counted since the last clear
        prog   = PROG_W'((32'(s.post) << pre_bits) | 32'(s.pre));
        // full time-out length in rc edges
        period = PROG_W'(32'h1 << (32'(post_sel) + 32'(pre_bits)));
        // open in the final fraction only, unless window disable is set
        win_ok = watchdog_config_word[CFG_WINDOW_DISABLE_BIT] |
                 ((CMP_W'(prog) << 3) >=
                  CMP_W'(32'(period) * 32'(wwdt_closed_eighths(window_select))));
    end

    // next-state logic
    always_comb begin
        next_s         = s;
        // pulses default low, counts hold
        next_s.tick_d  = tick_s;
        next_s.low_power_rc_clock_en = en;
        next_s.win     = win_ok;
        next_s.wake    = 1'b0;
        next_s.rst_req = 1'b0;
        next_s.timeout = 1'b0;
        clr            = 1'b0;

        // power-save entry from run
        if (lk.ps_enter && s.mode == WWDT_RUN) begin
            next_s.mode = lk.ps_idle ? WWDT_IDLE : WWDT_SLEEP;
            clr         = 1'b1;
        end

        // left power save for another cause
        if (lk.ps_exit && s.mode != WWDT_RUN) begin
            next_s.mode = WWDT_RUN;
            clr         = 1'b1;
        end

        // clock switch finished
        if (lk.switch_done) begin
            clr = 1'b1;
        end

        // clear instruction, honoured in run only
        if (lk.clear_pulse && s.mode == WWDT_RUN) begin
            clr = 1'b1;
            if (en && !win_ok) begin
                next_s.rst_req = 1'b1;
            end
        end

        // count rc edges in every mode
        if (en && tick_rise && !clr) begin
            if (s.pre == pre_last) begin
                // prescaler wrapped, step the postscaler
                next_s.pre = '0;
                if (s.post == post_last) begin
                    // time-out reached
                    next_s.post    = '0;
                    next_s.timeout = 1'b1;
                    // in run the time-out resets the device
                    if (s.mode == WWDT_RUN) begin
                        next_s.rst_req = 1'b1;
                    end else begin
                        // in sleep or idle it wakes the core
                        next_s.wake = 1'b1;
                        next_s.mode = WWDT_RUN;
                        clr         = 1'b1;
                    end
                end else begin
                    next_s.post = s.post + 1'b1;
                end
            end else begin
                // prescaler still counting
                next_s.pre = s.pre + 1'b1;
            end
        end

        // a disabled watchdog holds its counts at zero
        if (!en) begin
            // next enable starts a whole period
            clr = 1'b1;
        end

        // reset requested last cycle acts as device reset
        if (s.rst_req) begin
            // core drops its soft enable in the same cycle
            next_s.mode = WWDT_RUN;
            clr         = 1'b1;
        end

        // common clear of all counts
        if (clr) begin
            // shared by every clearing event
            next_s.pre  = '0;
            next_s.post = '0;
        end
    end

    // state register, frozen while ce low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // run mode, zero counts, no pulses
            s      <= '0;
            s.mode <= WWDT_RUN;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // outputs straight from flops
    // wake, reset request and time-out are one-cycle pulses
    assign lk.wake      = s.wake;
    assign lk.reset_req = s.rst_req;
    assign lk.timeout   = s.timeout;
    assign low_power_rc_clock_enable  = s.low_power_rc_clock_en;
    assign window_open  = s.win;
endmodule

// file: bench/wwdt_checker.sv
// link assertions between the watchdog and the core
`timescale 1ns/1ps
module wwdt_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear_pulse,
    input wire logic ps_enter,
    input wire logic ps_idle,
    input wire logic ps_exit,
    input wire logic switch_done,
    input wire logic soft_enable,
    input wire logic wake,
    input wire logic reset_req,
    input wire logic timeout
);
    logic       asleep; // core in sleep or idle
    logic [7:0] since;  // cycles since counts were cleared
    // track power mode and time since the last clearing event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asleep <= 1'b0;
            since <= 8'h00;
        end else begin
            if (ps_enter) begin
                asleep <= 1'b1;
            end else if (wake || ps_exit || reset_req) begin
                asleep <= 1'b0;
            end
            if (clear_pulse || ps_enter || ps_exit || switch_done || reset_req || wake) begin
                since <= 8'h00;
            end else if (since != 8'hFF) begin
                since <= since + 8'h01;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // no time-out for a while after counts are cleared
    sequence s_quiet; !timeout [*8]; endsequence
    property p_tmo_run; timeout && !asleep |-> reset_req && !wake; endproperty
    a_tmo_run: assert property (p_tmo_run) else $error("run time-out without reset");
    property p_tmo_ps; timeout && asleep |-> wake && !reset_req; endproperty
    a_tmo_ps: assert property (p_tmo_ps) else $error("power-save time-out without wake");
    property p_wake_cause; wake |-> timeout && asleep; endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without time-out");
    property p_period; timeout |-> since >= 8'h64; endproperty
    a_period: assert property (p_period) else $error("time-out too soon");
    property p_clear; clear_pulse |-> ##2 s_quiet; endproperty
    a_clear: assert property (p_clear) else $error("clear did not restart");
    property p_enter; ps_enter |-> ##2 s_quiet; endproperty
    a_enter: assert property (p_enter) else $error("entry did not restart");
    property p_exit; ps_exit |-> ##2 s_quiet; endproperty
    a_exit: assert property (p_exit) else $error("exit did not restart");
    property p_switch; switch_done |-> ##2 s_quiet; endproperty
    a_switch: assert property (p_switch) else $error("switch did not restart");
    property p_soft_rst; reset_req |-> ##[1:2] !soft_enable; endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft enable kept over reset");
    property p_clear_awake; clear_pulse |-> !asleep; endproperty
    a_clear_awake: assert property (p_clear_awake) else $error("clear sent while asleep");
endmodule

// file: bench/tb_top.sv
// self-checking bench: core and watchdog joined by their link
`timescale 1ns/1ps
module tb_top import wwdt_pkg::*; ;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er; // bus and reset
    logic [11:0] paddr;            // bus address
    logic [31:0] pwdata, prdata, rd; // bus data
    logic        fail_safe_switch, core_reset, rc_clk, low_power_rc_clock_enable, window_open; // side pins
    logic [7:0]  cfg;              // watchdog config word
    logic [1:0]  win;              // window setting
    int          err_count, total_checks, rst_cnt; // tallies
    wwdt_link_if lk();
    wwdt_core wwdt_core_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fail_safe_switch(fail_safe_switch), .lk(lk), .core_reset(core_reset));
    wwdt_device wwdt_device_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .low_power_rc_clock(rc_clk),
        .watchdog_config_word(cfg), .window_select(win), .lk(lk), .low_power_rc_clock_enable(low_power_rc_clock_enable),
        .window_open(window_open));
    wwdt_checker wwdt_checker_i (.pclk(pclk), .presetn(presetn), .clear_pulse(lk.clear_pulse),
        .ps_enter(lk.ps_enter), .ps_idle(lk.ps_idle), .ps_exit(lk.ps_exit), .switch_done(lk.switch_done),
        .soft_enable(lk.soft_enable), .wake(lk.wake), .reset_req(lk.reset_req), .timeout(lk.timeout));
    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // count core resets
    always @(posedge pclk) begin
        if (core_reset === 1'b1) begin
            rst_cnt++;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus transfer, result in rd and er
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // rc clock edges, six bus cycles each
    task automatic rc(input int n);
        repeat (n) begin
            rc_clk <= 1'b1;
            repeat (3) @(posedge pclk);
            rc_clk <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
    // run rc edges, then compare resets seen
    task automatic run_expect(input int n, input int exp);
        int b;
        b = rst_cnt;
        rc(n);
        repeat (6) @(posedge pclk);
        chk(32'(rst_cnt - b), 32'(exp));
    endtask
    task automatic do_reset(input logic [7:0] c, input logic [1:0] w);
        presetn <= 1'b0;
        cfg <= c;
        win <= w;
        rc_clk <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    // reset values, unmapped place, disabled watchdog
    task automatic t_regs();
        do_reset(8'h40, 2'h0);
        apb(1'b0, RESET_CONTROL_REG_OFF, 32'h0);
        chk(rd, RESET_CONTROL_REG_RESET);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, low_power_rc_clock_enable}, 32'h0);
        run_expect(40, 0);
    endtask
    // postscaler ratios with soft enable
    task automatic t_post();
        for (int p = 0; p < 3; p++) begin
            do_reset(8'h40 | 8'(p), 2'h0);
            apb(1'b1, RESET_CONTROL_REG_OFF, 32'h20);
            repeat (2) @(posedge pclk);
            chk({31'h0, low_power_rc_clock_enable}, 32'h1);
            run_expect((32 << p) - 1, 0);
            run_expect(1, 1);
            apb(1'b0, RESET_CONTROL_REG_OFF, 32'h0);
            chk(rd, 32'h12);
        end
    endtask
    // fixed enable, divide by 128, software cannot stop it
    task automatic t_fixed();
        do_reset(8'hD0, 2'h0);
        apb(1'b1, RESET_CONTROL_REG_OFF, 32'h0);
        run_expect(127, 0);
        run_expect(1, 1);
    endtask
    // clear, power-save exit, clock switch and fail-safe switch each restart the full period
    task automatic t_restart();
        for (int k = 0; k < 4; k++) begin
            do_reset(8'h40, 2'h0);
            apb(1'b1, RESET_CONTROL_REG_OFF, 32'h20);
            run_expect(20, 0);
            case (k)
                0: apb(1'b1, CTRL_OFF, 32'h1);
                1: begin
                    apb(1'b1, CTRL_OFF, 32'h2);
                    run_expect(20, 0);
                    apb(1'b1, CTRL_OFF, 32'h8);
                end
                2: begin
                    apb(1'b1, CTRL_OFF, 32'h10);
                    repeat (CLK_SWITCH_CYCLES + 4) @(posedge pclk);
                end
                default: begin
                    fail_safe_switch <= 1'b1;
                    @(posedge pclk);
                    fail_safe_switch <= 1'b0;
                end
            endcase
            run_expect(31, 0);
            run_expect(1, 1);
        end
    endtask
    // time-out in sleep and idle wakes without reset
    task automatic t_sleep();
        for (int k = 0; k < 2; k++) begin
            do_reset(8'h40, 2'h0);
            apb(1'b1, RESET_CONTROL_REG_OFF, 32'h20);
            apb(1'b1, CTRL_OFF, k ? 32'h4 : 32'h2);
            run_expect(32, 0);
            apb(1'b0, CTRL_OFF, 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, RESET_CONTROL_REG_OFF, 32'h0);
            chk(rd, k ? 32'h34 : 32'h38);
            apb(1'b1, RESET_CONTROL_REG_OFF, 32'h20);
            apb(1'b0, RESET_CONTROL_REG_OFF, 32'h0);
            chk(rd, 32'h20);
        end
    endtask
    // early clear resets, late clear restarts
    task automatic t_window();
        int closed [4] = '{24, 20, 16, 8};
        for (int w = 0; w < 4; w++) begin
            do_reset(8'h00, 2'(w));
            apb(1'b1, RESET_CONTROL_REG_OFF, 32'h20);
            run_expect(closed[w] - 3, 0);
            chk({31'h0, window_open}, 32'h0);
            apb(1'b1, CTRL_OFF, 32'h1);
            run_expect(0, 1);
            do_reset(8'h00, 2'(w));
            apb(1'b1, RESET_CONTROL_REG_OFF, 32'h20);
            run_expect(closed[w] + 2, 0);
            chk({31'h0, window_open}, 32'h1);
            apb(1'b1, CTRL_OFF, 32'h1);
            run_expect(28, 0);
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fail_safe_switch = 1'b0;
        rc_clk = 1'b0;
        cfg = 8'h40;
        win = 2'h0;
        err_count = 0;
        total_checks = 0;
        rst_cnt = 0;
        t_regs();
        t_post();
        t_fixed();
        t_restart();
        t_sleep();
        t_window();
        print_verdict();
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        print_verdict();
    end
endmodule
